/* File: hw/poc_defines.svh */
// Register offsets, reset values, setting ranges and timing counts of the
// phase overcurrent decision block. Included by the block and the bench.
// Assumes a 10 MHz processing clock and a word-aligned register port.
//
// What this block does
// - Derive general pickup and general trip from the per-phase statuses.
// - Present per-phase pickup and trip indications besides the general ones.
// - Block input, from user logic, disables the element; no pickup or trip.
// - Operation selects off (default), definite time or eleven inverse curves.
// - Pickup threshold in percent of nominal, 10 to 3000, step 1, default 200.
// - Time multiplier 0.05 to 15.00 in steps of 0.01.
// - Minimum delay for inverse curves 40 to 60000 ms, step 1, default 100.
// - Definite-time trip delay equals setting, 40 to 60000 ms, step 1.
// - Reset delay for IEC curves 60 to 60000 ms, step 1.
// - Emit an event on every on/off change of pickups and general outputs.
// - All per-phase and general statuses readable as live values.
// - Analogue input is the sampled value of the three phase currents.
// - Inverse operate time is multiplier times k over (ratio^alpha - 1) plus c, ratio stepped down to 20/10/5/2, or 1.1 below 2.
// - Above twenty times threshold the operate time is held at that value.
// - Minimum delay applies whenever longer than the inverse operate time.
// - IEC curves reset after fixed delay; ANSI after multiplier kr/(1-ratio^2), ratio taken as 0 below half threshold, else 0.5.
`ifndef POC_DEFINES_SVH
`define POC_DEFINES_SVH

`define POC_ADDR_OPER 8'h00
`define POC_ADDR_THRESH 8'h04
`define POC_ADDR_TMS 8'h08
`define POC_ADDR_MIN_DLY 8'h0C
`define POC_ADDR_DEF_DLY 8'h10
`define POC_ADDR_RST_DLY 8'h14
`define POC_ADDR_STATUS 8'h18

`define POC_THRESH_MIN 16'h000A
`define POC_THRESH_MAX 16'h0BB8
`define POC_THRESH_RST 16'h00C8
`define POC_TMS_MIN 11'h005
`define POC_TMS_MAX 11'h5DC
`define POC_TMS_RST 11'h064
`define POC_TMS_UNIT 32'h0000_0064
`define POC_DLY_MIN 16'h0028
`define POC_DLY_MAX 16'hEA60
`define POC_DLY_RST 16'h0064
`define POC_RST_DLY_MIN 16'h003C

`define POC_DROP_PCT 24'h00005F
`define POC_FULL_PCT 24'h000064

`define POC_CLK_PERIOD_NS 100
`define POC_TICK_NS 1000000
`define POC_TICK_CYCLES (`POC_TICK_NS / `POC_CLK_PERIOD_NS)

`endif

/* File: hw/poc_pkg.sv */
// Types of the phase overcurrent decision block.
// Assumes the constants header sits beside it.
package poc_pkg;

typedef enum logic [3:0] {
    POC_OFF = 4'h0,
    POC_DEF_TIME = 4'h1,
    POC_IEC_INV = 4'h2,
    POC_IEC_VINV = 4'h3,
    POC_IEC_EINV = 4'h4,
    POC_IEC_LINV = 4'h5,
    POC_ANSI_INV = 4'h6,
    POC_ANSI_MINV = 4'h7,
    POC_ANSI_VINV = 4'h8,
    POC_ANSI_EINV = 4'h9,
    POC_ANSI_LINV = 4'hA,
    POC_ANSI_LVINV = 4'hB,
    POC_ANSI_LEINV = 4'hC
} poc_oper_t;

typedef struct packed {
    logic [15:0] phase_c;
    logic [15:0] phase_b;
    logic [15:0] phase_a;
} poc_currents_t;

typedef struct packed {
    logic any_phase_trip;
    logic any_phase_pickup;
    logic phase_c_trip;
    logic phase_b_trip;
    logic phase_a_trip;
    logic phase_c_pickup;
    logic phase_b_pickup;
    logic phase_a_pickup;
} poc_status_t;

typedef struct packed {
    logic valid;
    logic [4:0] changed;
    logic [4:0] value;
} poc_event_t;

endpackage : poc_pkg

/* File: hw/poc_decision.sv */
// Phase overcurrent element: characteristic timing, decision logic, settings.
// Assumes currents are percent of nominal, synchronous to clk, one clock.
`timescale 1ns/1ns
`include "poc_defines.svh"

module poc_decision import poc_pkg::*; #(
    parameter int TICK_CYCLES = `POC_TICK_CYCLES
) (
    input wire logic clk, // 10 MHz processing clock
    input wire logic resetn, // async reset
    input wire poc_currents_t phase_current, // sampled phase currents, %In
    input wire logic element_block_in, // user blocking equation
    input wire logic [7:0] reg_addr, // register byte address
    input wire logic [31:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    output logic [31:0] reg_rdata, // read data, cycle after strobe
    output poc_status_t status, // live statuses
    output poc_event_t status_event // on/off change pulse
);

////////////////////////////////////////////////////////////////////////////////
// inverse curve tables, ms at multiplier 1.00, points 1.1/2/5/10/20 x threshold

function automatic logic [104:0] curve_row(input poc_oper_t op);
    case (op)
        POC_IEC_INV: curve_row = {21'd73400, 21'd10030, 21'd4280, 21'd2970, 21'd2270};
        POC_IEC_VINV: curve_row = {21'd135000, 21'd13500, 21'd3375, 21'd1500, 21'd711};
        POC_IEC_EINV: curve_row = {21'd380952, 21'd26667, 21'd3333, 21'd808, 21'd201};
        POC_IEC_LINV: curve_row = {21'd1200000, 21'd120000, 21'd30000, 21'd13333, 21'd6316};
        POC_ANSI_INV: curve_row = {21'd4526, 21'd635, 21'd281, 21'd201, 21'd159};
        POC_ANSI_MINV: curve_row = {21'd27104, 21'd3803, 21'd1689, 21'd1207, 21'd948};
        POC_ANSI_VINV: curve_row = {21'd93871, 21'd7028, 21'd1308, 21'd689, 21'd540};
        POC_ANSI_EINV: curve_row = {21'd134412, 21'd9522, 21'd1297, 21'd407, 21'd192};
        POC_ANSI_LINV: curve_row = {21'd45255, 21'd6345, 21'd2815, 21'd2011, 21'd1585};
        POC_ANSI_LVINV: curve_row = {21'd136662, 21'd10229, 21'd1902, 21'd1000, 21'd784};
        POC_ANSI_LEINV: curve_row = {21'd305350, 21'd21607, 21'd2920, 21'd897, 21'd411};
        default: curve_row = '0;
    endcase
endfunction : curve_row

// ansi reset constant kr in ms
function automatic logic [14:0] reset_kr(input poc_oper_t op);
    case (op)
        POC_ANSI_INV: reset_kr = 15'd460;
        POC_ANSI_MINV: reset_kr = 15'd4850;
        POC_ANSI_VINV: reset_kr = 15'd21600;
        POC_ANSI_EINV: reset_kr = 15'd29100;
        POC_ANSI_LINV: reset_kr = 15'd4600;
        POC_ANSI_LVINV: reset_kr = 15'd13460;
        POC_ANSI_LEINV: reset_kr = 15'd30000;
        default: reset_kr = '0;
    endcase
endfunction : reset_kr

function automatic logic [15:0] clamp16(input logic [31:0] v, input logic [15:0] lo,
                                        input logic [15:0] hi);
    if (v < {16'h0000, lo})
        clamp16 = lo;
    else if (v > {16'h0000, hi})
        clamp16 = hi;
    else
        clamp16 = v[15:0];
endfunction : clamp16

////////////////////////////////////////////////////////////////////////////////
// settings registers

poc_oper_t oper_r;
logic [15:0] thresh_r;
logic [10:0] tms_r;
logic [15:0] min_dly_r;
logic [15:0] def_dly_r;
logic [15:0] rst_dly_r;

wire wr_oper = reg_wr && reg_addr == `POC_ADDR_OPER;
wire wr_thresh = reg_wr && reg_addr == `POC_ADDR_THRESH;
wire wr_tms = reg_wr && reg_addr == `POC_ADDR_TMS;
wire wr_min = reg_wr && reg_addr == `POC_ADDR_MIN_DLY;
wire wr_def = reg_wr && reg_addr == `POC_ADDR_DEF_DLY;
wire wr_rst = reg_wr && reg_addr == `POC_ADDR_RST_DLY;
wire oper_legal = reg_wdata <= 32'h0000_000C;
wire [15:0] tms_clamped = clamp16(reg_wdata, {5'h00, `POC_TMS_MIN}, {5'h00, `POC_TMS_MAX});

always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        oper_r <= POC_OFF;
        thresh_r <= `POC_THRESH_RST;
        tms_r <= `POC_TMS_RST;
        min_dly_r <= `POC_DLY_RST;
        def_dly_r <= `POC_DLY_RST;
        rst_dly_r <= `POC_DLY_RST;
    end else begin
        if (wr_oper && oper_legal)
            oper_r <= poc_oper_t'(reg_wdata[3:0]);
        if (wr_thresh)
            thresh_r <= clamp16(reg_wdata, `POC_THRESH_MIN, `POC_THRESH_MAX);
        if (wr_tms)
            tms_r <= tms_clamped[10:0];
        if (wr_min)
            min_dly_r <= clamp16(reg_wdata, `POC_DLY_MIN, `POC_DLY_MAX);
        if (wr_def)
            def_dly_r <= clamp16(reg_wdata, `POC_DLY_MIN, `POC_DLY_MAX);
        if (wr_rst)
            rst_dly_r <= clamp16(reg_wdata, `POC_RST_DLY_MIN, `POC_DLY_MAX);
    end
end

////////////////////////////////////////////////////////////////////////////////
// register read, data one cycle after the strobe

poc_status_t status_r;
logic [31:0] rd_mux;

always_comb begin
    case (reg_addr)
        `POC_ADDR_OPER: rd_mux = {28'h0000000, oper_r};
        `POC_ADDR_THRESH: rd_mux = {16'h0000, thresh_r};
        `POC_ADDR_TMS: rd_mux = {21'h000000, tms_r};
        `POC_ADDR_MIN_DLY: rd_mux = {16'h0000, min_dly_r};
        `POC_ADDR_DEF_DLY: rd_mux = {16'h0000, def_dly_r};
        `POC_ADDR_RST_DLY: rd_mux = {16'h0000, rst_dly_r};
        `POC_ADDR_STATUS: rd_mux = {24'h000000, status_r};
        default: rd_mux = 32'h0000_0000;
    endcase
end

always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
        reg_rdata <= 32'h0000_0000;
    else if (reg_rd)
        reg_rdata <= rd_mux;
    else
        reg_rdata <= 32'h0000_0000;
end

////////////////////////////////////////////////////////////////////////////////
// millisecond tick

logic [31:0] tick_cnt_r;
wire tick = tick_cnt_r == 32'(TICK_CYCLES - 1);

always_ff @(posedge clk or negedge resetn) begin
    if (!resetn)
        tick_cnt_r <= 32'h0000_0000;
    else if (tick)
        tick_cnt_r <= 32'h0000_0000;
    else
        tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
end

////////////////////////////////////////////////////////////////////////////////
// per-phase characteristic timing

wire enabled = !element_block_in && oper_r != POC_OFF;
wire is_def = oper_r == POC_DEF_TIME;
wire is_iec = oper_r inside {POC_IEC_INV, POC_IEC_VINV, POC_IEC_EINV, POC_IEC_LINV};
wire [104:0] row = curve_row(oper_r);
wire [14:0] kr = reset_kr(oper_r);
wire [23:0] thr24 = {8'h00, thresh_r};
// one bit per phase, each bit driven from its own generate slice
wire [2:0] pick_nxt;
wire [2:0] trip_nxt;

genvar ph;
generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
        wire [23:0] g24 = {8'h00, phase_current[ph*16 +: 16]};
        wire above = g24 > thr24;
        // drop below 95 % of threshold, the reset ratio
        wire drop = g24 * `POC_FULL_PCT < thr24 * `POC_DROP_PCT;
        wire ge2 = g24 >= thr24 * 24'h000002;
        wire ge5 = g24 >= thr24 * 24'h000005;
        wire ge10 = g24 >= thr24 * 24'h00000A;
        wire ge20 = g24 >= thr24 * 24'h000014;
        wire half = g24 * 24'h000002 >= thr24;
        // stepwise curve: value at the lower ratio point of each bucket
        wire [2:0] bucket = ge20 ? 3'h4 : ge10 ? 3'h3 : ge5 ? 3'h2 : ge2 ? 3'h1 : 3'h0;
        wire [20:0] base = row[(3'h4 - bucket) * 21 +: 21];
        wire [31:0] inv_raw = {11'h000, base} * {21'h000000, tms_r} / `POC_TMS_UNIT;
        wire [31:0] min32 = {16'h0000, min_dly_r};
        wire [31:0] inv_need = inv_raw > min32 ? inv_raw : min32;
        wire [31:0] op_need = is_def ? {16'h0000, def_dly_r} : inv_need;
        wire [31:0] kr_t = {17'h00000, kr} * {21'h000000, tms_r} / `POC_TMS_UNIT;
        // ansi reset stretched by 4/3 while current stays above half threshold
        wire [31:0] ansi_rst = half ? kr_t + kr_t / 32'h0000_0003 : kr_t;
        wire [31:0] rst_need = is_def ? 32'h0000_0000
                             : is_iec ? {16'h0000, rst_dly_r} : ansi_rst;
        logic pick_r;
        logic trip_r;
        logic [31:0] op_cnt_r;
        logic [31:0] rst_cnt_r;
        wire p_nxt = enabled && (pick_r ? !drop : above);
        wire [31:0] op_inc = op_cnt_r < op_need ? op_cnt_r + 32'h0000_0001 : op_cnt_r;
        wire rst_done = rst_cnt_r + 32'h0000_0001 >= rst_need;

        assign pick_nxt[ph] = p_nxt;
        assign trip_nxt[ph] = p_nxt && (tick ? op_inc >= op_need : trip_r);

        always_ff @(posedge clk or negedge resetn) begin
            if (!resetn) begin
                pick_r <= 1'b0;
                trip_r <= 1'b0;
                op_cnt_r <= 32'h0000_0000;
                rst_cnt_r <= 32'h0000_0000;
            end else begin
                pick_r <= p_nxt;
                trip_r <= trip_nxt[ph];
                if (!enabled) begin
                    op_cnt_r <= 32'h0000_0000;
                    rst_cnt_r <= 32'h0000_0000;
                end else if (tick && p_nxt) begin
                    op_cnt_r <= op_inc;
                    rst_cnt_r <= 32'h0000_0000;
                end else if (tick && op_cnt_r != 32'h0000_0000) begin
                    if (rst_done) begin
                        op_cnt_r <= 32'h0000_0000;
                        rst_cnt_r <= 32'h0000_0000;
                    end else begin
                        rst_cnt_r <= rst_cnt_r + 32'h0000_0001;
                    end
                end
            end
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////////
// general outputs and events

poc_status_t status_nxt;
poc_event_t event_r;
wire [4:0] ev_now = {status_nxt.any_phase_trip, status_nxt.any_phase_pickup, pick_nxt};
wire [4:0] ev_was = {status_r.any_phase_trip, status_r.any_phase_pickup,
                     status_r.phase_c_pickup, status_r.phase_b_pickup,
                     status_r.phase_a_pickup};

always_comb begin
    status_nxt.phase_a_pickup = pick_nxt[0];
    status_nxt.phase_b_pickup = pick_nxt[1];
    status_nxt.phase_c_pickup = pick_nxt[2];
    status_nxt.phase_a_trip = trip_nxt[0];
    status_nxt.phase_b_trip = trip_nxt[1];
    status_nxt.phase_c_trip = trip_nxt[2];
    status_nxt.any_phase_pickup = enabled && |pick_nxt;
    status_nxt.any_phase_trip = enabled && |trip_nxt;
end

always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        status_r <= '0;
        event_r <= '0;
    end else begin
        status_r <= status_nxt;
        event_r.valid <= ev_now != ev_was;
        event_r.changed <= ev_now ^ ev_was;
        event_r.value <= ev_now;
    end
end

assign status = status_r;
assign status_event = event_r;

////////////////////////////////////////////////////////////////////////////////
// assertions

wire [2:0] st_pick = {status.phase_c_pickup, status.phase_b_pickup, status.phase_a_pickup};
wire [2:0] st_trip = {status.phase_c_trip, status.phase_b_trip, status.phase_a_trip};

property p_gen_or;
    @(posedge clk) disable iff (!resetn)
    status.any_phase_pickup == |st_pick && status.any_phase_trip == |st_trip;
endproperty
a_gen_or: assert property (p_gen_or) else $error("general output not OR of phases");

property p_trip_needs_pick;
    @(posedge clk) disable iff (!resetn)
    (st_trip & ~st_pick) == 3'h0;
endproperty
a_trip_needs_pick: assert property (p_trip_needs_pick) else $error("trip without pickup");

sequence s_blocked;
    element_block_in ##1 1'b1;
endsequence
property p_block;
    @(posedge clk) disable iff (!resetn)
    s_blocked |-> status_r == '0;
endproperty
a_block: assert property (p_block) else $error("output while blocked");

property p_off;
    @(posedge clk) disable iff (!resetn)
    oper_r == POC_OFF |=> status.any_phase_pickup == 1'b0;
endproperty
a_off: assert property (p_off) else $error("pickup while switched off");

property p_thresh_range;
    @(posedge clk) disable iff (!resetn)
    wr_thresh |=> thresh_r >= `POC_THRESH_MIN && thresh_r <= `POC_THRESH_MAX;
endproperty
a_thresh_range: assert property (p_thresh_range) else $error("threshold out of range");

property p_tms_range;
    @(posedge clk) disable iff (!resetn)
    tms_r >= `POC_TMS_MIN && tms_r <= `POC_TMS_MAX;
endproperty
a_tms_range: assert property (p_tms_range) else $error("multiplier out of range");

property p_min_write;
    @(posedge clk) disable iff (!resetn)
    wr_min && reg_wdata >= 32'h0000_0028 && reg_wdata <= 32'h0000_EA60
        |=> min_dly_r == $past(reg_wdata[15:0]);
endproperty
a_min_write: assert property (p_min_write) else $error("min delay not stored");

property p_def_range;
    @(posedge clk) disable iff (!resetn)
    wr_def |=> def_dly_r >= `POC_DLY_MIN && def_dly_r <= `POC_DLY_MAX;
endproperty
a_def_range: assert property (p_def_range) else $error("definite delay out of range");

property p_rst_range;
    @(posedge clk) disable iff (!resetn)
    rst_dly_r >= `POC_RST_DLY_MIN && rst_dly_r <= `POC_DLY_MAX;
endproperty
a_rst_range: assert property (p_rst_range) else $error("reset delay out of range");

property p_event;
    @(posedge clk) disable iff (!resetn)
    $changed(status.any_phase_trip) || $changed(status.phase_a_pickup)
        |-> status_event.valid;
endproperty
a_event: assert property (p_event) else $error("missing status event");

property p_trip_on_tick;
    @(posedge clk) disable iff (!resetn)
    $rose(status.phase_a_trip) |-> $past(tick);
endproperty
a_trip_on_tick: assert property (p_trip_on_tick) else $error("trip off the tick");

endmodule : poc_decision

/* File: bench/poc_trip_logic.sv */
// Far-side model: user blocking equation and downstream trip/event logic.
// Assumes the block's event outputs and one processing clock.
`timescale 1ns/1ns
module poc_trip_logic import poc_pkg::*; (
    input wire logic clk, // processing clock
    input wire logic resetn, // async reset, active low
    input wire logic block_req, // bench asks for blocking
    input wire logic evt_clr, // clears the event log
    input wire poc_event_t status_event, // event pulses from block
    output logic element_block_in, // equation output to block
    output logic [4:0] evt_seen, // changed bits gathered
    output logic [4:0] evt_last, // value of last event
    output logic [7:0] evt_count // events counted
);
////////////////////////////////////////////////////////////////////////////////
always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
        element_block_in <= 1'b0;
        evt_seen <= 5'h00;
        evt_last <= 5'h00;
        evt_count <= 8'h00;
    end else begin
        element_block_in <= block_req;
        if (evt_clr) begin
            evt_seen <= 5'h00;
            evt_count <= 8'h00;
        end else if (status_event.valid) begin
            evt_seen <= evt_seen | status_event.changed;
            evt_last <= status_event.value;
            evt_count <= evt_count + 8'h01;
        end
    end
end
endmodule : poc_trip_logic

/* File: bench/poc_decision_tb.sv */
// Self-checking bench of the phase overcurrent decision block.
// Assumes the far-side model beside it and a 1 ms tick of 10 cycles.
`timescale 1ns/1ns
`include "poc_defines.svh"
module poc_decision_tb import poc_pkg::*; ;
logic clk, resetn, reg_wr, reg_rd, block_req, evt_clr, element_block_in;
logic [7:0] reg_addr;
logic [31:0] reg_wdata, reg_rdata;
poc_currents_t phase_current;
poc_status_t status;
poc_event_t status_event;
logic [4:0] evt_seen, evt_last;
int err_total, check_count;
////////////////////////////////////////////////////////////////////////////////
poc_decision #(.TICK_CYCLES(10)) dut (.clk(clk), .resetn(resetn),
    .phase_current(phase_current), .element_block_in(element_block_in),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .status(status), .status_event(status_event));
poc_trip_logic far (.clk(clk), .resetn(resetn), .block_req(block_req),
    .evt_clr(evt_clr), .status_event(status_event),
    .element_block_in(element_block_in), .evt_seen(evt_seen),
    .evt_last(evt_last), .evt_count());
initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
end
////////////////////////////////////////////////////////////////////////////////
task stop_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
        $display("NO MISMATCHES");
    else
        $display("MISMATCHES SEEN");
    $finish;
endtask : stop_test
task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
        err_total++;
        $display("Error %s expected %h seen %h", what, exp, seen);
    end
endtask : check
task reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
endtask : reg_write
task reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
endtask : reg_read
task wait_bit(input int idx, input logic val, input int lim, output int n);
    n = 0;
    while (status[idx] !== val && n < lim) begin
        @(posedge clk);
        #1 n++;
    end
    if (status[idx] !== val) begin
        err_total++;
        $display("Error wait for status bit %0d timed out", idx);
        stop_test;
    end
endtask : wait_bit
// raises one fault, times the trip, removes it and lets timers reset
task run_trip(input poc_currents_t cur, input int lo, input int hi, input logic [7:0] st);
    int n, m;
    @(posedge clk);
    phase_current <= cur;
    evt_clr <= 1'b1;
    @(posedge clk);
    evt_clr <= 1'b0;
    wait_bit(7, 1'b1, hi + 20, n);
    check("trip time in window", 32'(n + 1 >= lo && n + 1 <= hi), 32'h1);
    check("status at trip", 32'(status), 32'(st));
    @(posedge clk);
    phase_current <= '0;
    wait_bit(6, 1'b0, 4, m);
    check("status after drop", 32'(status), 32'h0);
    repeat (1000) @(posedge clk);
endtask : run_trip
////////////////////////////////////////////////////////////////////////////////
initial begin
    int n;
    logic [31:0] d;
    logic [7:0] at [6];
    logic [31:0] dt [6];
    logic [7:0] ca [8];
    logic [31:0] cw [8];
    logic [31:0] ce [8];
    at = '{`POC_ADDR_OPER, `POC_ADDR_THRESH, `POC_ADDR_TMS, `POC_ADDR_MIN_DLY,
        `POC_ADDR_DEF_DLY, `POC_ADDR_RST_DLY};
    dt = '{32'h0, 32'hC8, 32'h64, 32'h64, 32'h64, 32'h64};
    ca = '{`POC_ADDR_THRESH, `POC_ADDR_THRESH, `POC_ADDR_TMS, `POC_ADDR_TMS,
        `POC_ADDR_MIN_DLY, `POC_ADDR_DEF_DLY, `POC_ADDR_DEF_DLY, `POC_ADDR_RST_DLY};
    cw = '{32'h5, 32'hFA0, 32'h1, 32'h7D0, 32'hA, 32'hA, 32'hEA61, 32'h28};
    ce = '{32'hA, 32'hBB8, 32'h5, 32'h5DC, 32'h28, 32'h28, 32'hEA60, 32'h3C};
    err_total = 0;
    check_count = 0;
    resetn = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    block_req = 1'b0;
    evt_clr = 1'b0;
    phase_current = '0;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
        reg_read(at[i], d);
        check("setting default", d, dt[i]);
    end
    reg_read(8'h1C, d);
    check("unmapped read", d, 32'h0);
    for (int i = 0; i < 8; i++) begin
        reg_write(ca[i], cw[i]);
        reg_read(ca[i], d);
        check("setting clamped", d, ce[i]);
    end
    for (int i = 0; i < 14; i++) begin
        reg_write(`POC_ADDR_OPER, 32'(i));
        reg_read(`POC_ADDR_OPER, d);
        check("operation mode", d, (i > 12) ? 32'hC : 32'(i));
    end
    reg_write(`POC_ADDR_OPER, 32'h0);
    reg_write(`POC_ADDR_THRESH, 32'hC8);
    reg_write(`POC_ADDR_DEF_DLY, 32'h28);
    phase_current <= '{16'h0, 16'h12C, 16'h0};
    repeat (600) @(posedge clk);
    check("off raises nothing", 32'(status), 32'h0);
    phase_current <= '0;
    reg_write(`POC_ADDR_OPER, 32'h1);
    phase_current <= '{16'h0, 16'hC8, 16'h0};
    repeat (20) @(posedge clk);
    check("at threshold no pickup", 32'(status), 32'h0);
    phase_current <= '{16'h0, 16'hC9, 16'h0};
    wait_bit(1, 1'b1, 4, n);
    #1 check("pickup phase b", 32'(status), 32'h42);
    phase_current <= '{16'h0, 16'hBF, 16'h0};
    repeat (20) @(posedge clk);
    check("hysteresis holds", 32'(status), 32'h42);
    phase_current <= '{16'h0, 16'hBD, 16'h0};
    wait_bit(1, 1'b0, 4, n);
    repeat (30) @(posedge clk);
    run_trip('{16'h0, 16'h12C, 16'h0}, 390, 420, 8'hD2);
    check("events gathered", 32'(evt_seen), 32'h1A);
    check("last event value", 32'(evt_last), 32'h0);
    block_req <= 1'b1;
    @(posedge clk);
    phase_current <= '{16'h0, 16'h0, 16'h12C};
    repeat (600) @(posedge clk);
    check("blocked raises nothing", 32'(status), 32'h0);
    block_req <= 1'b0;
    wait_bit(0, 1'b1, 6, n);
    reg_read(`POC_ADDR_STATUS, d);
    check("live status read", d, 32'h41);
    block_req <= 1'b1;
    wait_bit(6, 1'b0, 4, n);
    check("block clears pickup", 32'(status), 32'h0);
    block_req <= 1'b0;
    wait_bit(0, 1'b1, 6, n);
    reg_write(`POC_ADDR_OPER, 32'h0);
    wait_bit(6, 1'b0, 4, n);
    check("off clears pickup", 32'(status), 32'h0);
    phase_current <= '0;
    reg_write(`POC_ADDR_THRESH, 32'h64);
    reg_write(`POC_ADDR_RST_DLY, 32'h3C);
    reg_write(`POC_ADDR_TMS, 32'h64);
    reg_write(`POC_ADDR_OPER, 32'h3);
    run_trip('{16'h0, 16'h0, 16'h7D0}, 6750, 7460, 8'hC9);
    run_trip('{16'h0, 16'h0, 16'hBB8}, 6750, 7460, 8'hC9);
    // short gap below the reset delay keeps the elapsed time
    phase_current <= '{16'h0, 16'h0, 16'h7D0};
    repeat (3000) @(posedge clk);
    phase_current <= '0;
    repeat (300) @(posedge clk);
    phase_current <= '{16'h0, 16'h0, 16'h7D0};
    wait_bit(7, 1'b1, 4400, n);
    check("trip after short gap", 32'(n >= 4000 && n <= 4300), 32'h1);
    phase_current <= '0;
    repeat (1000) @(posedge clk);
    reg_write(`POC_ADDR_MIN_DLY, 32'h64);
    reg_write(`POC_ADDR_TMS, 32'h5);
    reg_write(`POC_ADDR_OPER, 32'h4);
    run_trip('{16'h7D0, 16'h0, 16'h0}, 990, 1020, 8'hE4);
    stop_test;
end
endmodule : poc_decision_tb
